/* File: hdl/abn_pkg.sv */
// Shared constants and types for the printer abnormal-condition logic
`default_nettype none
package abn_pkg;
  localparam int unsigned BUF_CHAR_W = 7;
  localparam int unsigned WHEEL_DATA_W = 6;
  localparam int unsigned GATE_W = 7;
  localparam int unsigned FAULT_N = 10;
  localparam int unsigned PCOUNT_W = 7;
  localparam logic [PCOUNT_W-1:0] PCOUNT_ONE = 7'h01;
  // Fault vector positions
  localparam int unsigned F_NO_PAPER = 0;
  localparam int unsigned F_NO_RIBBON = 1;
  localparam int unsigned F_CARRIAGE = 2;
  localparam int unsigned F_STOP = 3;
  localparam int unsigned F_SINGLE_LINE = 4;
  localparam int unsigned F_BUFFER = 5;
  localparam int unsigned F_WHEEL = 6;
  localparam int unsigned F_FEED = 7;
  localparam int unsigned F_FIRE = 8;
  localparam int unsigned F_EXTINGUISH = 9;
  // Reset values
  localparam logic FLAG_RESET = 1'b0;
  // Sequencer phases of an instruction's first step
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FORCE} seq_state_t;
endpackage : abn_pkg
`default_nettype wire

/* File: hdl/abn_if.sv */
// Interface between the printer abnormal logic and the processor sequencer
`default_nettype none
interface abn_if;
  logic abnormal_set_enable;
  logic abnormal_flag_out;
  logic single_line_stop_request;
  logic run_start;
  modport device (input abnormal_set_enable, input single_line_stop_request, input run_start,
    output abnormal_flag_out);
  modport host (output abnormal_set_enable, output single_line_stop_request, output run_start,
    input abnormal_flag_out);
endinterface : abn_if
`default_nettype wire

/* File: hdl/parity_check.sv */
// Buffer and wheel character parity checks, combinational
`default_nettype none
module parity_check
  import abn_pkg::*;
(
  // Buffer character, bit 6 is the check bit
  input wire logic [BUF_CHAR_W-1:0] buf_char,
  // Wheel character and check bit
  input wire logic [WHEEL_DATA_W-1:0] wheel_data,
  input wire logic wheel_check_bit,
  // Results
  output logic buf_bad,
  output logic wheel_bad
);
  // Two groups both odd or both even is an error
  assign buf_bad = ~((^buf_char[2:0]) ^ (^buf_char[6:3]));
  // Seven bits even parity is an error
  assign wheel_bad = ~((^wheel_data) ^ wheel_check_bit);
endmodule : parity_check
`default_nettype wire

/* File: hdl/abn_host.sv */
// Processor sequencer end: set enable and test-step override
`default_nettype none
module abn_host
  import abn_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link
  abn_if.host link,
  // Processor state
  input wire logic search_function,
  input wire logic processor_stopped,
  input wire logic one_line_button,
  input wire logic run_button,
  // Sequencer timing
  input wire logic first_step_function,
  input wire logic step_advance_phase,
  // Results
  output logic io_abnormal_r,
  output logic test_step_force_a,
  output logic test_step_force_b,
  output logic move_word_to_acc,
  output logic fetch_alternate_plus_one
);
  typedef struct packed {
    logic io_abn;
    logic hit;
    logic force_pend;
  } host_st_t;
  host_st_t s_r, s_nxt;
  // Enable only on search or stop
  assign link.abnormal_set_enable = search_function | processor_stopped;
  assign link.single_line_stop_request = one_line_button;
  assign link.run_start = run_button;
  // Override and its side effects for one phase
  assign test_step_force_a = s_r.force_pend;
  assign test_step_force_b = s_r.force_pend;
  assign move_word_to_acc = s_r.force_pend;
  assign fetch_alternate_plus_one = s_r.force_pend;
  assign io_abnormal_r = s_r.io_abn;
  // Next state: the flag is a register on this clock, so it is read directly at the step-advance phase
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.hit = 1'b0;
    // Override lands one phase after the flag is caught, so the normal step is already queued
    s_nxt.force_pend = s_r.hit;
    if (first_step_function && step_advance_phase && link.abnormal_flag_out)
    begin
      s_nxt.io_abn = 1'b1;
      s_nxt.hit = 1'b1;
    end
    else if (run_button)
    begin
      s_nxt.io_abn = FLAG_RESET;
    end
  end
  // State register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
endmodule : abn_host
`default_nettype wire

/* File: hdl/abn_device.sv */
// Printer abnormal-condition logic: fault flags and abnormal flag
`default_nettype none
// What this block does
// - OR ten faults, latch when enabled
// - Processor enables set only searching or stopped
// - Flag drives off-normal indication output
// - Flag at step-advance forces test step
// - Override moves word, fetches alternate plus one
// - Flag holds until printer panel clear
// - Buffer check only printing or interlock clear
// - Buffer error when both groups match parity
// - No buffer errors in space, sign phases
// - Check window from start sentinel to thirteenth
// - Buffer-error flag, cleared by run or clear
// - Wheel character even parity is code error
// - Wheel code error needs print, interlock clear, odd sprocket
// - Code gate in odd phase sets code error
// - Code-error flag indicates, cleared by clear/run
// - Paper, ribbon, carriage switches set and indicate
// - Stop request sets flag, lights stop lamps
// - Single-line request sets flag, halts next step
// - Feed overrun sets flag and lamp
// - Extinguish fault on late charge or bias loss
// - Extinguish fault blocks fire pulses, resets relay
module abn_device
  import abn_pkg::*;
#(
  parameter int unsigned FAULTS = FAULT_N
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link to the processor
  abn_if.device link,
  // Panel switches (asynchronous pins)
  input wire logic no_paper_pin,
  input wire logic no_ribbon_pin,
  input wire logic carriage_out_pin,
  input wire logic stop_pin,
  input wire logic feed_overrun_pin,
  input wire logic bias_missing_pin,
  input wire logic printer_clear_pin,
  // Print sequencing state (same clock)
  input wire logic print_active,
  input wire logic feed_interlock,
  input wire logic odd_sprocket_pulse,
  input wire logic odd_phase,
  input wire logic space_sign_phase,
  input wire logic start_sentinel,
  input wire logic thirteenth_word_count,
  input wire logic buf_char_strobe,
  input wire logic [BUF_CHAR_W-1:0] buf_char,
  input wire logic [WHEEL_DATA_W-1:0] wheel_data,
  input wire logic wheel_check_bit,
  input wire logic [GATE_W-1:0] code_gate_signal,
  // Charge circuit status
  input wire logic charge_pending,
  input wire logic charge_on,
  input wire logic drum_rev_count_a,
  input wire logic drum_rev_count_b,
  input wire logic no_print_select,
  input wire logic [PCOUNT_W-1:0] print_count,
  input wire logic count_step,
  input wire logic odd_fire_req,
  input wire logic even_fire_req,
  // Indications
  output logic off_normal,
  output logic no_paper_lamp,
  output logic no_ribbon_lamp,
  output logic carriage_lamp,
  output logic stop_lamp,
  output logic feed_check_lamp,
  output logic buffer_parity_fault,
  output logic wheel_code_fault,
  output logic feed_overrun_fault,
  output logic charge_fire_fault,
  output logic charge_extinguish_fault,
  output logic fire_pulse_inhibit,
  output logic charge_relay_reset,
  output logic odd_fire_pulse,
  output logic even_fire_pulse
);
  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic abn;
    logic window;
    logic buf_err;
    logic code_err;
    logic fire;
    logic ext;
    logic [FAULTS-1:0] lamps;
    logic odd_fire;
    logic even_fire;
  } dev_st_t;
  dev_st_t s_r, s_nxt;
  logic buf_bad, wheel_bad;
  logic paper_s, ribbon_s, carriage_s, stop_s, overrun_s, bias_s, clear_s;
  logic clr_any;
  logic [FAULTS-1:0] faults;
  // Parity logic shared by the two checks
  parity_check u_par (
    .buf_char(buf_char),
    .wheel_data(wheel_data),
    .wheel_check_bit(wheel_check_bit),
    .buf_bad(buf_bad),
    .wheel_bad(wheel_bad)
  );
  // Second synchroniser stage only
  assign {bias_s, clear_s, overrun_s, stop_s, carriage_s, ribbon_s, paper_s} = s_r.sync2;
  assign clr_any = clear_s | link.run_start;
  // Fault vector feeding the abnormal OR
  always_comb
  begin
    faults = '0;
    faults[F_NO_PAPER] = paper_s;
    faults[F_NO_RIBBON] = ribbon_s;
    faults[F_CARRIAGE] = carriage_s;
    faults[F_STOP] = stop_s;
    faults[F_SINGLE_LINE] = link.single_line_stop_request;
    faults[F_BUFFER] = s_r.buf_err;
    faults[F_WHEEL] = s_r.code_err;
    faults[F_FEED] = overrun_s;
    faults[F_FIRE] = s_r.fire;
    faults[F_EXTINGUISH] = s_r.ext;
  end
  // Next state of all flags; sets win over clears
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync1 = {bias_missing_pin, printer_clear_pin, feed_overrun_pin, stop_pin,
      carriage_out_pin, no_ribbon_pin, no_paper_pin};
    s_nxt.sync2 = s_r.sync1;
    // Buffer check window
    if (start_sentinel)
    begin
      s_nxt.window = 1'b1;
    end
    else if (thirteenth_word_count)
    begin
      s_nxt.window = 1'b0;
    end
    // Buffer error flag
    if (buf_char_strobe && buf_bad && s_r.window && !space_sign_phase
      && (print_active || !feed_interlock))
    begin
      s_nxt.buf_err = 1'b1;
    end
    else if (clr_any)
    begin
      s_nxt.buf_err = 1'b0;
    end
    // Code error flag; gate signals in odd phase flag a sprocket slip
    if ((wheel_bad && print_active && !feed_interlock && odd_sprocket_pulse)
      || (|code_gate_signal && odd_phase))
    begin
      s_nxt.code_err = 1'b1;
    end
    else if (clr_any)
    begin
      s_nxt.code_err = 1'b0;
    end
    // Charge fire fault
    if (charge_pending && drum_rev_count_a && drum_rev_count_b && !no_print_select)
    begin
      s_nxt.fire = 1'b1;
    end
    else if (clr_any)
    begin
      s_nxt.fire = 1'b0;
    end
    // Charge extinguish fault
    if ((!charge_on && print_count == PCOUNT_ONE && count_step && !print_active) || bias_s)
    begin
      s_nxt.ext = 1'b1;
    end
    else if (clr_any)
    begin
      s_nxt.ext = 1'b0;
    end
    // Abnormal flag holds until the panel clear, gated set enable
    if ((|faults) && link.abnormal_set_enable)
    begin
      s_nxt.abn = 1'b1;
    end
    else if (clear_s)
    begin
      s_nxt.abn = 1'b0;
    end
    s_nxt.lamps = faults;
    // Fire pulses blocked by extinguish fault
    s_nxt.odd_fire = odd_fire_req & ~s_r.ext;
    s_nxt.even_fire = even_fire_req & ~s_r.ext;
  end
  // State register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  // Outputs
  assign link.abnormal_flag_out = s_r.abn;
  assign off_normal = s_r.abn;
  assign no_paper_lamp = s_r.lamps[F_NO_PAPER];
  assign no_ribbon_lamp = s_r.lamps[F_NO_RIBBON];
  assign carriage_lamp = s_r.lamps[F_CARRIAGE];
  assign stop_lamp = s_r.lamps[F_STOP];
  assign feed_check_lamp = s_r.lamps[F_FEED];
  assign feed_overrun_fault = s_r.lamps[F_FEED];
  assign buffer_parity_fault = s_r.buf_err;
  assign wheel_code_fault = s_r.code_err;
  assign charge_fire_fault = s_r.fire;
  assign charge_extinguish_fault = s_r.ext;
  assign fire_pulse_inhibit = s_r.ext;
  assign charge_relay_reset = s_r.ext;
  assign odd_fire_pulse = s_r.odd_fire;
  assign even_fire_pulse = s_r.even_fire;
endmodule : abn_device
`default_nettype wire

/* File: testbench/abn_checker.sv */
// Link checks between the printer abnormal logic and the processor sequencer
`default_nettype none
module abn_checker
  import abn_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link signals
  input wire logic abnormal_set_enable,
  input wire logic abnormal_flag_out,
  input wire logic single_line_stop_request,
  input wire logic run_start
);
  timeunit 1ns;
  timeprecision 1ps;
  // Single-line request with enable sets the flag on the next cycle
  property p_line_sets;
    @(posedge clk) disable iff (reset) single_line_stop_request && abnormal_set_enable |=> abnormal_flag_out;
  endproperty
  a_line_sets: assert property (p_line_sets) else $error("flag not set by single line");
  // Flag may only rise after an edge where the set enable was high
  property p_set_gated;
    @(posedge clk) disable iff (reset) $rose(abnormal_flag_out) |-> $past(abnormal_set_enable);
  endproperty
  a_set_gated: assert property (p_set_gated) else $error("flag set without enable");
  // Run clears the fault flags but must leave the abnormal flag standing
  property p_run_keeps;
    @(posedge clk) disable iff (reset) abnormal_flag_out && run_start |=> abnormal_flag_out;
  endproperty
  a_run_keeps: assert property (p_run_keeps) else $error("flag cleared by run");
  // Flag cannot rise while the set enable is low
  property p_no_set_off;
    @(posedge clk) disable iff (reset) !abnormal_set_enable && !abnormal_flag_out |=> !abnormal_flag_out;
  endproperty
  a_no_set_off: assert property (p_no_set_off) else $error("flag set while enable low");
  // Run leaves the flag standing for the following cycles too
  property p_run_holds;
    @(posedge clk) disable iff (reset) abnormal_flag_out && run_start |=> abnormal_flag_out [*3];
  endproperty
  a_run_holds: assert property (p_run_holds) else $error("flag dropped after run");
  // A single-line request keeps the flag latched after the button is let go
  property p_line_holds;
    @(posedge clk) disable iff (reset) single_line_stop_request && abnormal_set_enable |=> abnormal_flag_out [*2];
  endproperty
  a_line_holds: assert property (p_line_holds) else $error("single line flag not held");
endmodule : abn_checker
`default_nettype wire

/* File: testbench/printer_abnormal_condition_logic_tb.sv */
// Bench joining both ends of the printer abnormal-condition link
`default_nettype none
module printer_abnormal_condition_logic_tb
  import abn_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus, quiet at time zero
  logic clk = '0, reset = '1, search_function = '0, processor_stopped = '0, one_line_button = '0, run_button = '0;
  logic first_step_function = '1, step_advance_phase = '0, no_paper_pin = '0, no_ribbon_pin = '0, stop_pin = '0;
  logic carriage_out_pin = '0, feed_overrun_pin = '0, bias_missing_pin = '0, printer_clear_pin = '0, odd_phase = '0;
  logic print_active = '0, feed_interlock = '1, odd_sprocket_pulse = '0, space_sign_phase = '0, start_sentinel = '0;
  logic thirteenth_word_count = '0, buf_char_strobe = '0, wheel_check_bit = '0, charge_pending = '0, charge_on = '1;
  logic drum_rev_count_a = '0, drum_rev_count_b = '0, no_print_select = '0, count_step = '0, odd_fire_req = '0;
  logic even_fire_req = '0;
  logic [BUF_CHAR_W-1:0] buf_char = '0;
  logic [WHEEL_DATA_W-1:0] wheel_data = '0;
  logic [GATE_W-1:0] code_gate_signal = '0;
  logic [PCOUNT_W-1:0] print_count = PCOUNT_ONE;
  // Design outputs
  logic io_abnormal_r, test_step_force_a, test_step_force_b, move_word_to_acc, fetch_alternate_plus_one;
  logic off_normal, no_paper_lamp, no_ribbon_lamp, carriage_lamp, stop_lamp, feed_check_lamp, buffer_parity_fault;
  logic wheel_code_fault, feed_overrun_fault, charge_fire_fault, charge_extinguish_fault, fire_pulse_inhibit;
  logic charge_relay_reset, odd_fire_pulse, even_fire_pulse;
  // Expected picture, notes and counters
  logic [18:0] e = '0, q[$];
  logic [1:0] pcnt = '0;
  logic [31:0] x = 32'h0000_3412;
  int fails = 0, cmp_count = 0;
  // Both ends face each other across one link
  abn_if link();
  abn_device u_abn_device (.clk, .reset, .link, .no_paper_pin, .no_ribbon_pin, .carriage_out_pin, .stop_pin,
    .feed_overrun_pin, .bias_missing_pin, .printer_clear_pin, .print_active, .feed_interlock, .odd_sprocket_pulse,
    .odd_phase, .space_sign_phase, .start_sentinel, .thirteenth_word_count, .buf_char_strobe, .buf_char,
    .wheel_data, .wheel_check_bit, .code_gate_signal, .charge_pending, .charge_on, .drum_rev_count_a,
    .drum_rev_count_b, .no_print_select, .print_count, .count_step, .odd_fire_req, .even_fire_req, .off_normal,
    .no_paper_lamp, .no_ribbon_lamp, .carriage_lamp, .stop_lamp, .feed_check_lamp, .buffer_parity_fault,
    .wheel_code_fault, .feed_overrun_fault, .charge_fire_fault, .charge_extinguish_fault, .fire_pulse_inhibit,
    .charge_relay_reset, .odd_fire_pulse, .even_fire_pulse);
  abn_host u_abn_host (.clk, .reset, .link, .search_function, .processor_stopped, .one_line_button, .run_button,
    .first_step_function, .step_advance_phase, .io_abnormal_r, .test_step_force_a, .test_step_force_b,
    .move_word_to_acc, .fetch_alternate_plus_one);
  abn_checker u_abn_checker (.clk, .reset, .abnormal_set_enable(link.abnormal_set_enable),
    .abnormal_flag_out(link.abnormal_flag_out), .single_line_stop_request(link.single_line_stop_request),
    .run_start(link.run_start));
  wire logic [18:0] obs = {even_fire_pulse, charge_relay_reset, feed_check_lamp, carriage_lamp, no_ribbon_lamp, pcnt,
    feed_overrun_fault, no_paper_lamp, io_abnormal_r, odd_fire_pulse, fire_pulse_inhibit,
    charge_extinguish_fault, charge_fire_fault, wheel_code_fault, buffer_parity_fault, stop_lamp, off_normal,
    link.abnormal_flag_out};
  // Free-running clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Xorshift source, fixed seed so runs repeat
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  task automatic check(logic [18:0] s, logic [18:0] w);
    cmp_count++;
    if (s !== w)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, w);
    end
  endtask : check
  task automatic end_sim();
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic run(int n);
    repeat (n) @(posedge clk);
  endtask : run
  // One strobed buffer character, then time for fault and flag to land
  task automatic buf_put(logic [6:0] c);
    buf_char <= c;
    buf_char_strobe <= '1;
    run(1);
    buf_char_strobe <= '0;
    run(4);
  endtask : buf_put
  // Panel clear passes a two-stage synchroniser, so it is held two cycles
  task automatic clr();
    printer_clear_pin <= '1;
    run(2);
    printer_clear_pin <= '0;
    run(5);
    e[1:0] = '0;
    e[7:3] = '0;
    e[17] = 1'b0;
  endtask : clr
  task automatic runb();
    run_button <= '1;
    run(1);
    run_button <= '0;
    run(4);
  endtask : runb
  // Counts forced test steps; all four strobes must come together
  always @(posedge clk)
    if (test_step_force_a && test_step_force_b && move_word_to_acc && fetch_alternate_plus_one)
      pcnt <= pcnt + 2'h1;
  // Every queued note, oldest first, against outputs, after the edge's updates have landed
  always @(negedge clk)
    while (q.size() > 0)
      check(obs, q.pop_front());
  // Main sequence
  initial
  begin
    logic [6:0] c;
    logic bad;
    run(3);
    reset <= '0;
    stop_pin <= '1;
    no_paper_pin <= '1;
    no_ribbon_pin <= '1;
    carriage_out_pin <= '1;
    feed_overrun_pin <= '1;
    step_advance_phase <= '1;
    run(1);
    step_advance_phase <= '0;
    run(5);
    e[2] = '1;
    e[11:10] = '1;
    e[16:14] = '1;
    q.push_back(e);
    search_function <= '1;
    one_line_button <= '1;
    run(1);
    one_line_button <= '0;
    run(4);
    e[1:0] = '1;
    q.push_back(e);
    step_advance_phase <= '1;
    run(1);
    step_advance_phase <= '0;
    run(5);
    e[13:12] = 2'h1;
    e[9] = '1;
    q.push_back(e);
    // Step phase outside the first step function must not force a test step
    first_step_function <= '0;
    step_advance_phase <= '1;
    run(1);
    step_advance_phase <= '0;
    first_step_function <= '1;
    run(4);
    q.push_back(e);
    // Pins drop first, so run is not fighting a live fault
    stop_pin <= '0;
    no_paper_pin <= '0;
    no_ribbon_pin <= '0;
    carriage_out_pin <= '0;
    feed_overrun_pin <= '0;
    run(5);
    runb();
    e[2] = '0;
    e[11:9] = '0;
    e[16:14] = '0;
    q.push_back(e);
    clr();
    q.push_back(e);
    // Buffer window opened; bad character in the space phase is ignored
    print_active <= '1;
    start_sentinel <= '1;
    run(1);
    start_sentinel <= '0;
    space_sign_phase <= '1;
    buf_put(7'h00);
    space_sign_phase <= '0;
    q.push_back(e);
    bad = '0;
    for (int i = 0; i < 20 && !bad; i++)
    begin
      c = 7'(rnd());
      bad = (^c[2:0]) == (^c[6:3]);
      buf_put(c);
      e[3] = bad;
      e[1:0] = {2{bad}};
      q.push_back(e);
    end
    fails += int'(!bad);
    runb();
    e[3] = '0;
    q.push_back(e);
    thirteenth_word_count <= '1;
    run(1);
    thirteenth_word_count <= '0;
    buf_put(7'h00);
    q.push_back(e);
    clr();
    // Wheel character: odd total passes, even total is a code fault
    feed_interlock <= '0;
    c = 7'(rnd());
    wheel_data <= c[5:0];
    wheel_check_bit <= ~^c[5:0];
    odd_sprocket_pulse <= '1;
    run(4);
    q.push_back(e);
    wheel_check_bit <= ^c[5:0];
    run(4);
    e[4] = '1;
    e[1:0] = '1;
    q.push_back(e);
    odd_sprocket_pulse <= '0;
    runb();
    e[4] = '0;
    q.push_back(e);
    clr();
    odd_phase <= '1;
    code_gate_signal <= 7'h40;
    run(1);
    odd_phase <= '0;
    code_gate_signal <= '0;
    print_active <= '0;
    feed_interlock <= '1;
    run(4);
    e[4] = '1;
    e[1:0] = '1;
    q.push_back(e);
    clr();
    // Charge still pending on the second revolution, masked by no-print
    charge_pending <= '1;
    drum_rev_count_a <= '1;
    drum_rev_count_b <= '1;
    no_print_select <= '1;
    odd_fire_req <= '1;
    even_fire_req <= '1;
    run(4);
    e[8] = '1;
    e[18] = '1;
    q.push_back(e);
    no_print_select <= '0;
    run(4);
    e[5] = '1;
    e[1:0] = '1;
    q.push_back(e);
    charge_pending <= '0;
    clr();
    // Extinguish fault from a late charge at count one blocks fire pulses
    charge_on <= '0;
    count_step <= '1;
    run(1);
    count_step <= '0;
    charge_on <= '1;
    run(4);
    e[8:6] = 3'h3;
    e[18:17] = 2'h1;
    e[1:0] = '1;
    q.push_back(e);
    clr();
    bias_missing_pin <= '1;
    run(6);
    bias_missing_pin <= '0;
    e[1:0] = '1;
    e[7:6] = '1;
    e[18:17] = 2'h1;
    q.push_back(e);
    // Let the watcher take the last note before the verdict
    run(2);
    end_sim();
  end
endmodule : printer_abnormal_condition_logic_tb
`default_nettype wire
